// >>> hdl/sfs_frontend.sv
// spi front end, write protection and busy tracking of a serial flash
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module sfs_frontend #(
   parameter int unsigned PUW_CYCLES = sfs_pkg::POWERUP_WRITE_CYCLES
) (
   input  wire logic                      sys_clk,          // system clock, 100 MHz
   input  wire logic                      rst,              // supply-threshold reset, high
   input  wire sfs_pkg::sfs_pins_s        pins,             // raw spi and control pins
   output logic                           serial_out,       // serial data out, registered
   output logic                           serial_out_oe_n,  // low while serial_out driven
   input  wire sfs_pkg::sfs_bus_s         bus_req,          // register port request
   output logic [sfs_pkg::DATA_W-1:0]     bus_rdata         // read data, cycle after strobe
);

   localparam int CNT_W = $clog2(PUW_CYCLES + 1);

   // ************************************************************
   // decode helpers
   // ************************************************************
   function automatic logic is_write_op(input logic [7:0] op);
      is_write_op = (op == sfs_pkg::OP_WRITE_ENABLE) || (op == sfs_pkg::OP_WRITE_DISABLE) ||
                    (op == sfs_pkg::OP_WRITE_STATUS) || (op == sfs_pkg::OP_PAGE_PROGRAM) ||
                    (op == sfs_pkg::OP_SECTOR_ERASE) || (op == sfs_pkg::OP_CHIP_ERASE);
   endfunction

   function automatic logic is_array_op(input logic [7:0] op);
      is_array_op = (op == sfs_pkg::OP_PAGE_PROGRAM) || (op == sfs_pkg::OP_SECTOR_ERASE) ||
                    (op == sfs_pkg::OP_CHIP_ERASE);
   endfunction

   function automatic logic [8:0] min_len(input logic [7:0] op);
      if (op == sfs_pkg::OP_WRITE_STATUS) begin
         min_len = sfs_pkg::LEN_WRITE_STATUS;
      end else if (op == sfs_pkg::OP_SECTOR_ERASE) begin
         min_len = sfs_pkg::LEN_SECTOR_ERASE;
      end else if (op == sfs_pkg::OP_PAGE_PROGRAM) begin
         min_len = sfs_pkg::LEN_PAGE_PROGRAM;
      end else begin
         min_len = sfs_pkg::LEN_SINGLE;
      end
   endfunction

   // ************************************************************
   // pin synchronisation and edge detection
   // ************************************************************
   sfs_pkg::sfs_pins_s pin_s;
   logic               sclk_prev_q;
   logic               sel_prev_q;

   sfs_sync #(
      .W       (5),
      .RST_VAL (sfs_pkg::PINS_RST)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (pins),
      .q       (pin_s)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         sel_prev_q  <= 1'b0;
      end else begin
         sclk_prev_q <= pin_s.sclk;
         sel_prev_q  <= pin_s.select_n;
      end
   end

   // idle level of the clock does not matter, only its edges
   wire sclk_rise  = pin_s.sclk & ~sclk_prev_q;
   wire sclk_fall  = ~pin_s.sclk & sclk_prev_q;
   wire sel_fall   = sel_prev_q & ~pin_s.select_n;
   wire sel_rise   = ~sel_prev_q & pin_s.select_n;
   wire selected   = ~pin_s.select_n;
   wire protect_on = ~pin_s.protect_n;

   // ************************************************************
   // power-up lockouts
   // ************************************************************
   logic             armed_q;
   logic [CNT_W-1:0] pu_cnt_q;

   wire lockout = (pu_cnt_q != CNT_W'(PUW_CYCLES));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         armed_q  <= 1'b0;
         pu_cnt_q <= '0;
      end else begin
         if (sel_fall) begin
            armed_q <= 1'b1;
         end
         if (lockout) begin
            pu_cnt_q <= CNT_W'(pu_cnt_q + 1'b1);
         end
      end
   end

   // ************************************************************
   // pause control
   // ************************************************************
   logic paused_q;

   // a pause requested while the clock is high waits for its falling edge
   wire hold_begin = selected & ~paused_q & ~pin_s.pause_n & ~pin_s.sclk;
   wire hold_end   = paused_q & pin_s.pause_n & ~pin_s.sclk;

   always_ff @(posedge sys_clk) begin
      if (rst || !selected) begin
         paused_q <= 1'b0;
      end else if (hold_begin) begin
         paused_q <= 1'b1;
      end else if (hold_end) begin
         paused_q <= 1'b0;
      end
   end

   // ************************************************************
   // receive shifter and frame state
   // ************************************************************
   sfs_pkg::sfs_frame_e frame_q;
   logic [2:0]          bit_cnt_q;
   logic [8:0]          byte_cnt_q;
   logic [7:0]          rx_q;
   logic [7:0]          opcode_q;
   logic [7:0]          wrsr_byte_q;
   logic                busy_q;
   logic                pd_q;

   wire in_frame  = (frame_q == sfs_pkg::FR_OPCODE) || (frame_q == sfs_pkg::FR_BODY);
   // frozen while paused, so shifter and counters resume where they stopped
   wire shift_in  = sclk_rise & selected & ~paused_q & in_frame;
   wire shift_out = sclk_fall & selected & ~paused_q;
   wire [7:0] rx_next   = {rx_q[6:0], pin_s.serial_in};
   wire       byte_done = shift_in & (bit_cnt_q == sfs_pkg::BIT_LAST);

   // gating applied once the opcode byte is complete
   wire op_allowed = pd_q   ? (rx_next == sfs_pkg::OP_RELEASE_PD) :
                     busy_q ? (rx_next == sfs_pkg::OP_READ_STATUS) :
                     1'b1;

   always_ff @(posedge sys_clk) begin
      if (rst || !selected) begin
         frame_q <= sfs_pkg::FR_IDLE;
      end else if (sel_fall && armed_q) begin
         frame_q <= sfs_pkg::FR_OPCODE;
      end else if (sel_fall) begin
         frame_q <= sfs_pkg::FR_OPCODE;
      end else if (byte_done && frame_q == sfs_pkg::FR_OPCODE) begin
         frame_q <= op_allowed ? sfs_pkg::FR_BODY : sfs_pkg::FR_IGNORE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || sel_fall) begin
         bit_cnt_q  <= sfs_pkg::BIT_FIRST;
         byte_cnt_q <= '0;
         rx_q       <= '0;
      end else if (shift_in) begin
         bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
         rx_q      <= rx_next;
         if (byte_done && byte_cnt_q != sfs_pkg::BYTE_CNT_MAX) begin
            byte_cnt_q <= 9'(byte_cnt_q + 1'b1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         opcode_q    <= '0;
         wrsr_byte_q <= '0;
      end else if (byte_done) begin
         if (frame_q == sfs_pkg::FR_OPCODE) begin
            opcode_q <= rx_next;
         end
         if (byte_cnt_q == sfs_pkg::IDX_STATUS_BYTE) begin
            wrsr_byte_q <= rx_next;
         end
      end
   end

   // ************************************************************
   // instruction commit at the end of the frame
   // ************************************************************
   logic       wl_q;
   logic       lock_q;
   logic [2:0] region_q;
   logic       op_is_wrsr_q;
   logic [7:0] pend_status_q;
   logic [7:0] launch_op_q;
   logic       pend_q;
   logic       op_done;

   wire on_boundary = (bit_cnt_q == sfs_pkg::BIT_FIRST);
   wire long_enough = (byte_cnt_q >= min_len(opcode_q));
   wire frame_ok    = ~is_write_op(opcode_q) | (on_boundary & long_enough);
   wire commit      = sel_rise & (frame_q == sfs_pkg::FR_BODY) & frame_ok;

   wire do_wren  = commit & (opcode_q == sfs_pkg::OP_WRITE_ENABLE) & ~lockout;
   wire do_wrdi  = commit & (opcode_q == sfs_pkg::OP_WRITE_DISABLE);
   wire wr_ok    = wl_q & ~lockout;
   wire do_wrsr  = commit & (opcode_q == sfs_pkg::OP_WRITE_STATUS) & wr_ok &
                   ~(lock_q & protect_on);
   wire do_array = commit & is_array_op(opcode_q) & wr_ok;
   wire do_pd    = commit & (opcode_q == sfs_pkg::OP_POWER_DOWN);
   wire do_rel   = commit & (opcode_q == sfs_pkg::OP_RELEASE_PD);
   wire finish   = op_done & busy_q;

   // busy survives deselect; only completion from the array side ends it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_q       <= 1'b0;
         op_is_wrsr_q <= 1'b0;
      end else if (do_wrsr || do_array) begin
         busy_q       <= 1'b1;
         op_is_wrsr_q <= do_wrsr;
      end else if (finish) begin
         busy_q       <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wl_q <= 1'b0;
      end else if (do_wren) begin
         wl_q <= 1'b1;
      end else if (do_wrdi || finish) begin
         wl_q <= 1'b0;
      end
   end

   // lock and region bits come back at reset as unprotected
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_q        <= 1'b0;
         region_q      <= sfs_pkg::REGION_RST;
         pend_status_q <= '0;
      end else begin
         if (do_wrsr) begin
            pend_status_q <= wrsr_byte_q;
         end
         if (finish && op_is_wrsr_q) begin
            lock_q   <= pend_status_q[7];
            region_q <= pend_status_q[4:2];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pd_q <= 1'b0;
      end else if (do_pd) begin
         pd_q <= 1'b1;
      end else if (do_rel) begin
         pd_q <= 1'b0;
      end
   end

   // ************************************************************
   // status byte and transmit shifter
   // ************************************************************
   sfs_pkg::sfs_status_s status;
   logic [7:0]           tx_q;
   logic                 tx_en_q;

   assign status = '{lock: lock_q, rsv: sfs_pkg::STATUS_RSV_VAL, region: region_q,
                     wl: wl_q, busy: busy_q};

   wire rdsr_now = (frame_q == sfs_pkg::FR_OPCODE) ? (rx_next == sfs_pkg::OP_READ_STATUS) :
                   (frame_q == sfs_pkg::FR_BODY) & (opcode_q == sfs_pkg::OP_READ_STATUS);
   // reload on every byte so a held select streams fresh status
   wire tx_load  = byte_done & rdsr_now & ~pd_q;

   always_ff @(posedge sys_clk) begin
      if (rst || !selected) begin
         tx_en_q <= 1'b0;
         tx_q    <= '0;
      end else if (tx_load) begin
         tx_en_q <= 1'b1;
         tx_q    <= status;
      end else if (shift_out && tx_en_q) begin
         tx_q    <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         serial_out <= 1'b0;
      end else if (shift_out && tx_en_q) begin
         serial_out <= tx_q[7];
      end
   end

   assign serial_out_oe_n = ~(selected & ~paused_q & tx_en_q);

   // ************************************************************
   // register port
   // ************************************************************
   logic [sfs_pkg::DATA_W-1:0] rd_mux;
   logic [sfs_pkg::DATA_W-1:0] stat_word;
   logic [sfs_pkg::DATA_W-1:0] launch_word;
   logic [sfs_pkg::DATA_W-1:0] rx_word;

   wire ctrl_wr   = bus_req.wr & (bus_req.addr == sfs_pkg::REG_CTRL);
   assign op_done = ctrl_wr & bus_req.wdata[sfs_pkg::CTRL_OP_DONE];
   wire clr_pend  = ctrl_wr & bus_req.wdata[sfs_pkg::CTRL_CLR_PEND];

   // a launch in the same cycle as a clear keeps the pending flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_q      <= 1'b0;
         launch_op_q <= '0;
      end else if (do_wrsr || do_array) begin
         pend_q      <= 1'b1;
         launch_op_q <= opcode_q;
      end else if (clr_pend) begin
         pend_q      <= 1'b0;
      end
   end

   always_comb begin
      stat_word                         = '0;
      stat_word[7:0]                    = status;
      stat_word[sfs_pkg::STX_POWER_DOWN] = pd_q;
      stat_word[sfs_pkg::STX_PAUSED]     = paused_q;
      stat_word[sfs_pkg::STX_LOCKOUT]    = lockout;
      stat_word[sfs_pkg::STX_SELECTED]   = selected;
      launch_word                        = '0;
      launch_word[7:0]                   = launch_op_q;
      launch_word[sfs_pkg::LAUNCH_PEND_BIT] = pend_q;
      rx_word                            = '0;
      rx_word[7:0]                       = rx_q;
      rx_word[sfs_pkg::RX_CNT_LSB +: sfs_pkg::BYTE_CNT_W] = byte_cnt_q;
   end

   assign rd_mux = (bus_req.addr == sfs_pkg::REG_STATUS) ? stat_word   :
                   (bus_req.addr == sfs_pkg::REG_LAUNCH) ? launch_word :
                   (bus_req.addr == sfs_pkg::REG_RXDATA) ? rx_word     :
                   '0;

   // read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_rdata <= '0;
      end else begin
         bus_rdata <= bus_req.rd ? rd_mux : '0;
      end
   end

endmodule

// >>> shared/sfs_pkg.sv
// shared constants, types and register map of the serial flash front end
package sfs_pkg;

   // ************************************************************
   // instruction codes
   // ************************************************************
   localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
   localparam logic [7:0] OP_READ_STATUS    = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
   localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE   = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE     = 8'hC7;
   localparam logic [7:0] OP_POWER_DOWN     = 8'hB9;
   localparam logic [7:0] OP_RELEASE_PD     = 8'hAB;

   // least frame length in bytes, opcode included
   localparam int         BYTE_CNT_W        = 9;
   localparam logic [8:0] LEN_SINGLE        = 9'h001;
   localparam logic [8:0] LEN_WRITE_STATUS  = 9'h002;
   localparam logic [8:0] LEN_SECTOR_ERASE  = 9'h004;
   localparam logic [8:0] LEN_PAGE_PROGRAM  = 9'h005;
   localparam logic [8:0] BYTE_CNT_MAX      = 9'h1FF;
   localparam logic [8:0] IDX_STATUS_BYTE   = 9'h001;

   localparam logic [2:0] BIT_LAST          = 3'h7;
   localparam logic [2:0] BIT_FIRST         = 3'h0;

   // ************************************************************
   // status byte, msb is the lock bit, lsb the busy flag
   // ************************************************************
   typedef struct packed {
      logic       lock;
      logic [1:0] rsv;
      logic [2:0] region;
      logic       wl;
      logic       busy;
   } sfs_status_s;

   localparam logic [1:0] STATUS_RSV_VAL    = 2'h0;
   localparam logic [2:0] REGION_RST        = 3'h0;

   // ************************************************************
   // pins and register port
   // ************************************************************
   typedef struct packed {
      logic select_n;
      logic sclk;
      logic serial_in;
      logic pause_n;
      logic protect_n;
   } sfs_pins_s;

   // select_n starts low so a pin held low at power-up shows no falling edge
   localparam logic [4:0] PINS_RST          = 5'h03;

   localparam int         ADDR_W            = 4;
   localparam int         DATA_W            = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } sfs_bus_s;

   localparam logic [3:0] REG_STATUS        = 4'h0;
   localparam logic [3:0] REG_LAUNCH        = 4'h4;
   localparam logic [3:0] REG_CTRL          = 4'h8;
   localparam logic [3:0] REG_RXDATA        = 4'hC;

   localparam int         CTRL_OP_DONE      = 0;
   localparam int         CTRL_CLR_PEND     = 1;
   localparam int         STX_POWER_DOWN    = 8;
   localparam int         STX_PAUSED        = 9;
   localparam int         STX_LOCKOUT       = 10;
   localparam int         STX_SELECTED      = 11;
   localparam int         LAUNCH_PEND_BIT   = 8;
   localparam int         RX_CNT_LSB        = 8;

   // ************************************************************
   // frame states
   // ************************************************************
   typedef enum logic [1:0] {
      FR_IDLE   = 2'b00,
      FR_OPCODE = 2'b01,
      FR_BODY   = 2'b10,
      FR_IGNORE = 2'b11
   } sfs_frame_e;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int         SYS_CLK_MHZ           = 100;
   localparam int         POWERUP_WRITE_DELAY_US = 10;
   localparam int         POWERUP_WRITE_CYCLES  = POWERUP_WRITE_DELAY_US * SYS_CLK_MHZ;

endpackage

// >>> hdl/sfs_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sfs_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         sys_clk,   // system clock
   input  wire logic         rst,       // synchronous reset
   input  wire logic [W-1:0] d,         // asynchronous inputs
   output logic      [W-1:0] q          // synchronised outputs
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// >>> tb/sfs_frontend_chk.sv
// port checker for the serial flash front end
`timescale 1ns/10ps
module sfs_frontend_chk #(
   parameter int unsigned PUW_CYCLES = sfs_pkg::POWERUP_WRITE_CYCLES
) (
   input wire logic                       sys_clk,          // system clock
   input wire logic                       rst,              // reset, high
   input wire sfs_pkg::sfs_pins_s         pins,             // raw pins
   input wire logic                       serial_out,       // serial data out
   input wire logic                       serial_out_oe_n,  // enable, low
   input wire sfs_pkg::sfs_bus_s          bus_req,          // register request
   input wire logic [sfs_pkg::DATA_W-1:0] bus_rdata         // read data
);
   // ************************************************************
   // helper counters
   // ************************************************************
   logic [15:0] since_rst_q;
   logic [3:0]  fall_age_q;
   logic        sclk_q;
   wire         unmapped = (bus_req.addr != sfs_pkg::REG_STATUS) &&
                           (bus_req.addr != sfs_pkg::REG_LAUNCH) &&
                           (bus_req.addr != sfs_pkg::REG_RXDATA);
   // reads taken well inside the power-up write window
   wire         lockout_early = (32'(since_rst_q) + 8) < PUW_CYCLES;

   always_ff @(posedge sys_clk) begin
      if (rst) since_rst_q <= 16'h0000;
      else if (since_rst_q != 16'hFFFF) since_rst_q <= since_rst_q + 16'h0001;
   end

   // raw pin fall, so the bound below covers synchroniser and edge detect
   always_ff @(posedge sys_clk) begin
      sclk_q <= pins.sclk;
      if (sclk_q && !pins.sclk) fall_age_q <= 4'h0;
      else if (fall_age_q != 4'hF) fall_age_q <= fall_age_q + 4'h1;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence desel_s; pins.select_n [*4]; endsequence
   sequence paused_s; (!pins.select_n && !pins.pause_n && !pins.sclk) [*5]; endsequence
   sequence stat_rd_s; bus_req.rd && bus_req.addr == sfs_pkg::REG_STATUS; endsequence
   sequence so_move_s; $changed(serial_out) && !serial_out_oe_n; endsequence
   sequence done_rd_s;
      bus_req.wr && bus_req.addr == sfs_pkg::REG_CTRL && bus_req.wdata[0] ##1 stat_rd_s;
   endsequence

   desel_hiz_a: assert property (desel_s |-> serial_out_oe_n)
      else $error("output driven while deselected");
   pause_hiz_a: assert property (paused_s |-> serial_out_oe_n)
      else $error("output driven while paused");
   fall_shift_a: assert property (so_move_s |-> fall_age_q <= 4'h6)
      else $error("output bit changed away from a clock fall");
   done_clears_a: assert property (done_rd_s |=> bus_rdata[1:0] == 2'b00)
      else $error("busy or latch left set after completion");
   lockout_seen_a: assert property ((stat_rd_s and lockout_early)
      |=> bus_rdata[sfs_pkg::STX_LOCKOUT] && !bus_rdata[1])
      else $error("write lockout missing after reset");
   busy_latch_a: assert property (stat_rd_s |=> !(bus_rdata[0] && !bus_rdata[1]))
      else $error("busy without the write latch");
   reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
      rst [*2] |-> serial_out_oe_n && bus_rdata == '0) else $error("activity during reset");
   unmapped_zero_a: assert property (bus_req.rd && unmapped |=> bus_rdata == '0)
      else $error("unmapped read returned data");
   rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
      else $error("read data outside its cycle");
endmodule

bind sfs_frontend sfs_frontend_chk #(.PUW_CYCLES(PUW_CYCLES)) u_sfs_frontend_chk (
   .sys_clk(sys_clk), .rst(rst), .pins(pins), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n), .bus_req(bus_req), .bus_rdata(bus_rdata));

// >>> tb/sfs_host.sv
// spi host model that drives the flash front end pins
`timescale 1ns/10ps
module sfs_host (
   output wire sfs_pkg::sfs_pins_s pins,             // pins toward the device
   input  wire logic               prot_n,           // protect level from bench
   input  wire logic               serial_out,       // device data out
   input  wire logic               serial_out_oe_n   // device enable, low
);
   logic sel_n = 1'b0;
   logic sck = 1'b0;
   logic sdi = 1'b0;
   logic hold_n = 1'b1;
   logic so_last = 1'b0;
   // a released line shows the inverse of its last value, never a lucky match
   wire  so_line = serial_out_oe_n ? ~so_last : serial_out;
   assign pins = '{sel_n, sck, sdi, hold_n, prot_n};
   always @(serial_out) so_last = serial_out;

   task automatic frame(input int n, input logic [39:0] d, input bit m3, input int pz,
                        output logic [7:0] rx);
      int b;
      int k;
      sck = m3;
      #62.5 sel_n = 1'b0;
      for (b = 0; b < n; b++) begin
         #62.5 sck = 1'b0;
         sdi = d[39-b];
         if (b == pz) begin
            #20 hold_n = 1'b0;
            for (k = 0; k < 6; k++) begin
               #62.5 sck = ~sck;
               sdi = ~sdi;
            end
            #100 hold_n = 1'b1;
         end
         #62.5 sck = 1'b1;
         rx = {rx[6:0], so_line};
      end
      #62.5 sck = m3;
      #62.5 sel_n = 1'b1;
      sdi = ~sdi;
      #500;
   endtask
endmodule

// >>> tb/sfs_frontend_tb.sv
// self-checking bench for the serial flash front end
`timescale 1ns/10ps
module sfs_frontend_tb;
   localparam int PUW = 1000;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic prot_n = 1'b1;
   logic rd_q = 1'b0;
   logic oe_seen = 1'b0;
   logic serial_out;
   logic serial_out_oe_n;
   logic [7:0] rx;
   logic [31:0] bus_rdata;
   logic [31:0] st = 32'h0000003E;
   logic [31:0] exp_q[$];
   sfs_pkg::sfs_bus_s  bus_req = '0;
   sfs_pkg::sfs_pins_s pins;
   logic [7:0] ops [3] = '{sfs_pkg::OP_PAGE_PROGRAM, sfs_pkg::OP_SECTOR_ERASE,
                           sfs_pkg::OP_CHIP_ERASE};
   logic [8:0] lens [3] = '{sfs_pkg::LEN_PAGE_PROGRAM, sfs_pkg::LEN_SECTOR_ERASE,
                            sfs_pkg::LEN_SINGLE};
   int failures = 0;
   int comparisons = 0;
   int i;

   always #5 sys_clk = ~sys_clk;

   sfs_frontend #(.PUW_CYCLES(PUW)) u_sfs_frontend (.sys_clk(sys_clk), .rst(rst), .pins(pins),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .bus_req(bus_req),
      .bus_rdata(bus_rdata));
   sfs_host u_sfs_host (.pins(pins), .prot_n(prot_n), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
      bus_req <= '{a, d, w, r};
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 32'h00000000);
      bus(1'b0, 1'b0, 4'h0, 32'h00000000);
   endtask
   task automatic sr(input logic [31:0] e);
      rd(sfs_pkg::REG_STATUS, e);
   endtask
   task automatic fr(input int n, input logic [7:0] op, input logic [31:0] t = 32'h00000000,
                     input bit m3 = 1'b0, input int pz = -1);
      u_sfs_host.frame(n, {op, t}, m3, pz, rx);
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   task automatic tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // the monitor owns every read result; drivers only leave notes
   always @(posedge sys_clk) begin
      rd_q <= bus_req.rd;
      if (serial_out_oe_n === 1'b0) oe_seen <= 1'b1;
      if (rd_q) check("bus_rdata", bus_rdata, exp_q.pop_front());
   end

   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      // host holds select low from power-up, so the selected bit shows
      sr(32'h00000C00);
      rd(4'h2, 32'h00000000);
      rd(sfs_pkg::REG_CTRL, 32'h00000000);
      fr(16, sfs_pkg::OP_READ_STATUS);
      check("oe_seen", {31'h0, oe_seen}, 32'h00000000);
      fr(8, sfs_pkg::OP_WRITE_ENABLE);
      sr(32'h00000400);
      repeat (700) @(posedge sys_clk);
      sr(32'h00000000);
      $display("test power-up done");
      fr(8, sfs_pkg::OP_WRITE_ENABLE);
      sr(32'h00000002);
      fr(8, sfs_pkg::OP_WRITE_DISABLE);
      sr(32'h00000000);
      fr(8, sfs_pkg::OP_WRITE_ENABLE);
      fr(19, sfs_pkg::OP_WRITE_STATUS, 32'h9C000000);
      sr(32'h00000002);
      fr(16, sfs_pkg::OP_WRITE_STATUS, 32'h9C000000);
      sr(32'h00000003);
      rd(sfs_pkg::REG_LAUNCH, 32'h00000101);
      bus(1'b1, 1'b0, sfs_pkg::REG_CTRL, 32'h00000003);
      sr(32'h0000009C);
      prot_n <= 1'b0;
      fr(8, sfs_pkg::OP_WRITE_ENABLE);
      fr(16, sfs_pkg::OP_WRITE_STATUS);
      sr(32'h0000009E);
      prot_n <= 1'b1;
      fr(16, sfs_pkg::OP_WRITE_STATUS);
      bus(1'b1, 1'b0, sfs_pkg::REG_CTRL, 32'h00000003);
      sr(32'h00000000);
      $display("test protection done");
      for (i = 0; i < 3; i++) begin
         fr(8, sfs_pkg::OP_WRITE_ENABLE);
         fr(int'(lens[i]) * 8, ops[i], xs());
         fr(8, sfs_pkg::OP_WRITE_DISABLE);
         // pause in the middle of the streamed status byte
         fr(16, sfs_pkg::OP_READ_STATUS, 32'h00000000, 1'b1, 12);
         check("status_byte", {24'h0, rx}, 32'h00000003);
         rd(sfs_pkg::REG_LAUNCH, {23'h0, 1'b1, ops[i]});
         sr(32'h00000003);
         bus(1'b1, 1'b0, sfs_pkg::REG_CTRL, 32'h00000003);
         sr(32'h00000000);
         rd(sfs_pkg::REG_LAUNCH, {24'h0, ops[i]});
      end
      $display("test busy operations done");
      fr(8, sfs_pkg::OP_POWER_DOWN);
      sr(32'h00000100);
      fr(8, sfs_pkg::OP_WRITE_ENABLE);
      sr(32'h00000100);
      fr(8, sfs_pkg::OP_RELEASE_PD);
      fr(8, sfs_pkg::OP_WRITE_ENABLE, 32'h00000000, 1'b0, 4);
      sr(32'h00000002);
      $display("test power-down and pause done");
      tally_and_finish();
   end
endmodule
